// >>> acp_map.vh
// register map and field constants for the signal path configuration block
// assumes an 8-bit register port with byte addresses as printed
`ifndef ACP_MAP_VH
`define ACP_MAP_VH
// register offsets
`define ACP_TAP_CFG      8'h47
`define ACP_OR_UV_CFG    8'h48
`define ACP_TRIG_DEC_CFG 8'h49
`define ACP_LP_X_OFS     8'h4a
`define ACP_LP_Y_OFS     8'h4b
`define ACP_LP_Z_OFS     8'h4c
`define ACP_LN_X_OFS     8'h4d
`define ACP_LN_Y_OFS     8'h4e
`define ACP_LN_Z_OFS     8'h4f
`define ACP_FILT_CFG     8'h50
`define ACP_TEMP_OFS     8'h55
`define ACP_TEMP_CTRL    8'h56
// writable bit masks, reserved bits clear
`define ACP_TAP_MASK     8'h07
`define ACP_OR_MASK      8'h1f
`define ACP_TRIG_MASK    8'he7
`define ACP_TOFS_MASK    8'h3f
`define ACP_TCTL_MASK    8'hdf
`define ACP_RST_VAL      8'h00
// field positions
`define ACP_TAP_TRIPLE   2
`define ACP_UV_OFF       4
`define ACP_OR_DET_OFF   3
`define ACP_OR_GUARD_OFF 2
`define ACP_DEC2_SKIP    7
`define ACP_SINC_RATIO   6
`define ACP_IIR_EN       5
`define ACP_ROUND        2
`define ACP_TRIG_PIN     1
`define ACP_TRIG_EXT     0
`define ACP_DROOP_SKIP   7
`define ACP_EQ_SKIP      6
`define ACP_HIGHPASS_PATH_SELECT     3
`define ACP_TRIM_EN      7
`define ACP_TGAIN_HIGH   6
// overrange output policy codes
`define ACP_OR_FULLSCALE 2'b00
`define ACP_OR_HOLD      2'b01
// operating mode codes on mode_sel
`define ACP_M_HP         3'h0
`define ACP_M_LP         3'h1
`define ACP_M_RBW        3'h2
`define ACP_M_ULP        3'h3
`define ACP_M_VLP        3'h4
`define ACP_M_HS         3'h5
// signed full scale codes
`define ACP_FS_POS       16'h7fff
`define ACP_FS_NEG       16'h8000
// sensitivity trim unity gain, one part in 128 per step
`define ACP_SENS_UNITY   9'h080
`define ACP_SENS_SHIFT   7
`define ACP_TOFS_SHIFT   2
`define ACP_OFS_FRAC     3
`endif

// >>> acp_top.v
// configuration and sample conditioning for the accelerometer signal path
// assumes one clock mclk, sync reset rst, pins arrive unsynchronised
`timescale 1ns/1ns
`include "acp_map.vh"

module acp_top #(
    parameter CONV_PERIOD = 1000
) (
    input  wire        mclk,
    input  wire        rst,
    // register port
    input  wire        reg_we,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata_q,
    // operating mode and pins
    input  wire [2:0]  mode_sel,
    input  wire        pulse_density_output,
    input  wire        frame_sync_pin,
    input  wire        second_interrupt_pin,
    input  wire        brownout_raw,
    input  wire        overscale_raw,
    // sample stream in
    input  wire        in_valid,
    output reg         in_ready_q,
    input  wire [1:0]  in_axis,
    input  wire        in_lownoise,
    input  wire        in_over,
    input  wire [15:0] in_data,
    // sample stream out
    output reg         out_valid_q,
    input  wire        out_ready,
    output reg  [1:0]  out_axis_q,
    output reg  [15:0] out_data_q,
    // temperature
    input  wire        temp_valid,
    input  wire [15:0] temp_raw,
    input  wire [5:0]  factory_temp_ofs,
    input  wire [4:0]  factory_temp_sens,
    output reg  [15:0] temp_out_q,
    output reg         temp_gain_high_q,
    // control outputs to the signal path
    output reg         tap_triple_en_q,
    output reg  [1:0]  tap_axis_q,
    output reg         brownout_flag_q,
    output reg         overscale_flag_q,
    output reg         excitation_off_q,
    output reg         second_decim_en_q,
    output reg         first_decim_16_q,
    output reg         recursive_en_q,
    output reg         droop_en_q,
    output reg         equalizer_en_q,
    output reg  [1:0]  lowpass_cutoff_q,
    output reg  [2:0]  highpass_corner_q,
    output reg         highpass_lownoise_q,
    output reg         conv_start_q
);

    reg [7:0] tap_q, oruv_q, trig_q, filt_q, tofs_q, tctl_q;
    reg [7:0] lp_ofs_q [0:2];
    reg [7:0] ln_ofs_q [0:2];
    reg [15:0] last_q [0:2];
    reg [2:0] fs_sync_q, i1_sync_q;
    reg [1:0] bo_sync_q, ov_sync_q;
    reg [15:0] conv_cnt_q;
    reg        skid_v_q;
    reg [17:0] skid_q;
    integer    i;
    integer    j; // own index so the hold bank has a single driver

    // writes keep only defined bits so reserved ones stay zero
    always @(posedge mclk) begin
        if (rst) begin
            tap_q  <= `ACP_RST_VAL;
            oruv_q <= `ACP_RST_VAL;
            trig_q <= `ACP_RST_VAL;
            filt_q <= `ACP_RST_VAL;
            tofs_q <= `ACP_RST_VAL;
            tctl_q <= `ACP_RST_VAL;
            for (i = 0; i < 3; i = i + 1) begin
                lp_ofs_q[i] <= `ACP_RST_VAL;
                ln_ofs_q[i] <= `ACP_RST_VAL;
            end
        end else if (reg_we) begin
            if (reg_addr == `ACP_TAP_CFG)
                tap_q <= reg_wdata & `ACP_TAP_MASK;
            else if (reg_addr == `ACP_OR_UV_CFG)
                oruv_q <= reg_wdata & `ACP_OR_MASK;
            else if (reg_addr == `ACP_TRIG_DEC_CFG)
                trig_q <= reg_wdata & `ACP_TRIG_MASK;
            else if (reg_addr == `ACP_LP_X_OFS)
                lp_ofs_q[0] <= reg_wdata;
            else if (reg_addr == `ACP_LP_Y_OFS)
                lp_ofs_q[1] <= reg_wdata;
            else if (reg_addr == `ACP_LP_Z_OFS)
                lp_ofs_q[2] <= reg_wdata;
            else if (reg_addr == `ACP_LN_X_OFS)
                ln_ofs_q[0] <= reg_wdata;
            else if (reg_addr == `ACP_LN_Y_OFS)
                ln_ofs_q[1] <= reg_wdata;
            else if (reg_addr == `ACP_LN_Z_OFS)
                ln_ofs_q[2] <= reg_wdata;
            else if (reg_addr == `ACP_FILT_CFG)
                filt_q <= reg_wdata;
            else if (reg_addr == `ACP_TEMP_OFS)
                tofs_q <= reg_wdata & `ACP_TOFS_MASK;
            else if (reg_addr == `ACP_TEMP_CTRL)
                tctl_q <= reg_wdata & `ACP_TCTL_MASK;
            // any other address falls through and the write is dropped
        end
    end

    // read data registered; unmapped addresses answer zero
    always @(posedge mclk) begin
        if (rst)
            reg_rdata_q <= 8'h00;
        else if (reg_addr == `ACP_TAP_CFG)
            reg_rdata_q <= tap_q;
        else if (reg_addr == `ACP_OR_UV_CFG)
            reg_rdata_q <= oruv_q;
        else if (reg_addr == `ACP_TRIG_DEC_CFG)
            reg_rdata_q <= trig_q;
        else if (reg_addr == `ACP_LP_X_OFS)
            reg_rdata_q <= lp_ofs_q[0];
        else if (reg_addr == `ACP_LP_Y_OFS)
            reg_rdata_q <= lp_ofs_q[1];
        else if (reg_addr == `ACP_LP_Z_OFS)
            reg_rdata_q <= lp_ofs_q[2];
        else if (reg_addr == `ACP_LN_X_OFS)
            reg_rdata_q <= ln_ofs_q[0];
        else if (reg_addr == `ACP_LN_Y_OFS)
            reg_rdata_q <= ln_ofs_q[1];
        else if (reg_addr == `ACP_LN_Z_OFS)
            reg_rdata_q <= ln_ofs_q[2];
        else if (reg_addr == `ACP_FILT_CFG)
            reg_rdata_q <= filt_q;
        else if (reg_addr == `ACP_TEMP_OFS)
            reg_rdata_q <= tofs_q;
        else if (reg_addr == `ACP_TEMP_CTRL)
            reg_rdata_q <= tctl_q;
        else
            reg_rdata_q <= 8'h00;
    end

    // pin synchronisers; only stage two onward is looked at
    always @(posedge mclk) begin
        if (rst) begin
            fs_sync_q <= 3'b000;
            i1_sync_q <= 3'b000;
            bo_sync_q <= 2'b00;
            ov_sync_q <= 2'b00;
        end else begin
            fs_sync_q <= {fs_sync_q[1:0], frame_sync_pin};
            i1_sync_q <= {i1_sync_q[1:0], second_interrupt_pin};
            bo_sync_q <= {bo_sync_q[0], brownout_raw};
            ov_sync_q <= {ov_sync_q[0], overscale_raw};
        end
    end

    // mode decode shared by the filter enables
    wire m_hp  = (mode_sel == `ACP_M_HP);
    wire m_lp  = (mode_sel == `ACP_M_LP);
    wire m_rbw = (mode_sel == `ACP_M_RBW);
    wire m_ln  = m_hp | m_lp | m_rbw;
    // equalizer bypass gates the low-pass, and the recursive reuse in HP mode only
    wire eq_skip = filt_q[`ACP_EQ_SKIP];
    wire [1:0] lpf_code = filt_q[5:4];

    // external trigger: rising edge of the chosen pin after sync
    wire pin_sel = trig_q[`ACP_TRIG_PIN] ? i1_sync_q[1] : fs_sync_q[1];
    wire pin_old = trig_q[`ACP_TRIG_PIN] ? i1_sync_q[2] : fs_sync_q[2];
    wire pin_rise = pin_sel & ~pin_old;
    // counter restarts whenever external mode is left, so phase is fresh
    wire int_tick = (conv_cnt_q == CONV_PERIOD[15:0] - 16'h0001);

    // conversion start pulse, internal counter idles in external mode
    always @(posedge mclk) begin
        if (rst) begin
            conv_cnt_q   <= 16'h0000;
            conv_start_q <= 1'b0;
        end else if (trig_q[`ACP_TRIG_EXT]) begin
            conv_cnt_q   <= 16'h0000;
            conv_start_q <= pin_rise;
        end else begin
            conv_cnt_q   <= int_tick ? 16'h0000 : conv_cnt_q + 16'h0001;
            conv_start_q <= int_tick;
        end
    end

    // control levels for the filter chain and analog front end
    always @(posedge mclk) begin
        if (rst) begin
            tap_triple_en_q     <= 1'b0;
            tap_axis_q          <= 2'b00;
            brownout_flag_q     <= 1'b0;
            overscale_flag_q    <= 1'b0;
            excitation_off_q    <= 1'b0;
            second_decim_en_q   <= 1'b0;
            first_decim_16_q    <= 1'b0;
            recursive_en_q      <= 1'b0;
            droop_en_q          <= 1'b0;
            equalizer_en_q      <= 1'b0;
            lowpass_cutoff_q    <= 2'b00;
            highpass_corner_q   <= 3'b000;
            highpass_lownoise_q <= 1'b0;
        end else begin
            tap_triple_en_q  <= tap_q[`ACP_TAP_TRIPLE];
            tap_axis_q       <= tap_q[1:0];
            brownout_flag_q  <= bo_sync_q[1] &
                                ~oruv_q[`ACP_UV_OFF];
            overscale_flag_q <= ov_sync_q[1] &
                                ~oruv_q[`ACP_OR_DET_OFF];
            // guard off keeps excitation running through the event
            excitation_off_q <= ov_sync_q[1] &
                                ~oruv_q[`ACP_OR_DET_OFF] &
                                ~oruv_q[`ACP_OR_GUARD_OFF];
            first_decim_16_q <= trig_q[`ACP_SINC_RATIO];
            second_decim_en_q <= ~trig_q[`ACP_SINC_RATIO] &
                                 ~trig_q[`ACP_DEC2_SKIP];
            recursive_en_q   <= trig_q[`ACP_IIR_EN] &
                                ((m_hp & eq_skip) | m_rbw | m_lp) &
                                (lpf_code == 2'b00);
            droop_en_q       <= ~filt_q[`ACP_DROOP_SKIP];
            equalizer_en_q   <= m_hp & ~eq_skip;
            lowpass_cutoff_q <= (m_ln & eq_skip) ?
                                lpf_code : 2'b00;
            highpass_corner_q   <= filt_q[2:0];
            highpass_lownoise_q <= filt_q[`ACP_HIGHPASS_PATH_SELECT];
        end
    end

    // clamp a 17-bit signed value into 16 bits
    function [15:0] sat16;
        input [16:0] v;
        begin
            if (v[16] != v[15])
                sat16 = v[16] ? `ACP_FS_NEG : `ACP_FS_POS;
            else
                sat16 = v[15:0];
        end
    endfunction

    // offset is added in eighth-LSB units before dropping the fraction
    wire [1:0] ax = (in_axis == 2'b11) ? 2'b00 : in_axis;
    wire [7:0] ofs = (in_axis == 2'b11) ? 8'h00 :
                     in_lownoise ? ln_ofs_q[ax]
                                 : lp_ofs_q[ax];
    wire [19:0] fine = {in_data[15], in_data, 3'b000} +
                       {{12{ofs[7]}}, ofs};
    wire [16:0] whole = fine[19:3];
    wire hpf_here = (filt_q[2:0] != 3'b000) &
                    (filt_q[`ACP_HIGHPASS_PATH_SELECT] == in_lownoise);
    // lifting floored negatives trims the dc bias only where hpf runs
    wire rnd_up = hpf_here & trig_q[`ACP_ROUND] &
                  whole[16];
    wire [15:0] clean = sat16(whole + {16'h0000, rnd_up});
    // pdm output bypasses substitution entirely
    wire over = in_over & ~oruv_q[`ACP_OR_DET_OFF] &
                ~pulse_density_output;
    reg [15:0] word;

    // overrange substitution by policy
    always @* begin
        word = clean;
        if (over) begin
            if (oruv_q[1:0] == `ACP_OR_FULLSCALE)
                word = in_data[15] ? `ACP_FS_NEG
                                   : `ACP_FS_POS;
            else if (oruv_q[1:0] == `ACP_OR_HOLD)
                word = last_q[ax];
        end
    end

    // at most one word enters per cycle, gated by registered ready
    wire accept = in_valid & in_ready_q;

    // last clean sample per axis, frozen while overrange lasts
    always @(posedge mclk) begin
        if (rst) begin
            for (j = 0; j < 3; j = j + 1)
                last_q[j] <= 16'h0000;
        end else if (accept & ~over & (in_axis != 2'b11)) begin
            last_q[ax] <= clean;
        end
    end

    // two-entry skid buffer so a stalled receiver loses no word
    wire out_free = ~out_valid_q | out_ready;
    wire skid_v_d = out_free ? 1'b0 : (skid_v_q | accept);

    always @(posedge mclk) begin
        if (rst) begin
            out_valid_q <= 1'b0;
            out_axis_q  <= 2'b00;
            out_data_q  <= 16'h0000;
            skid_v_q    <= 1'b0;
            skid_q      <= 18'h0_0000;
            in_ready_q  <= 1'b0;
        end else begin
            in_ready_q <= ~skid_v_d; // back-pressure to the source
            skid_v_q   <= skid_v_d;
            if (out_free) begin
                if (skid_v_q) begin
                    out_valid_q <= 1'b1;
                    {out_axis_q, out_data_q} <= skid_q;
                end else begin
                    out_valid_q <= accept;
                    {out_axis_q, out_data_q} <= {in_axis, word};
                end
            end else if (accept) begin
                skid_q <= {in_axis, word};
            end
        end
    end

    // temperature: offset then gain trim, user or factory values
    wire       use_user = tctl_q[`ACP_TRIM_EN];
    wire [5:0] t_ofs  = use_user ? tofs_q[5:0]
                                 : factory_temp_ofs;
    wire [4:0] t_sens = use_user ? tctl_q[4:0]
                                 : factory_temp_sens;
    // offset lsb carries the weight of data bit 2
    wire [16:0] t_sum = {temp_raw[15], temp_raw} +
                        {{9{t_ofs[5]}}, t_ofs, 2'b00};
    wire [8:0]  t_gain = `ACP_SENS_UNITY +
                         {{4{t_sens[4]}}, t_sens};
    wire signed [26:0] t_prod = $signed(t_sum) *
                                $signed({1'b0, t_gain});
    // dropping seven bits removes the unity weight of 128
    // trim ranges keep the result inside 17 signed bits
    wire [19:0] t_scaled = t_prod[26:7];

    always @(posedge mclk) begin
        if (rst) begin
            temp_out_q       <= 16'h0000;
            temp_gain_high_q <= 1'b0;
        end else begin
            temp_gain_high_q <= tctl_q[`ACP_TGAIN_HIGH];
            if (temp_valid)
                temp_out_q <= sat16(t_scaled[16:0]);
        end
    end

endmodule // acp_top

// >>> acp_top_assertions.sv
// port-level assertions for the signal path configuration block
// assumes binding onto acp_top, one clock mclk, sync reset rst
`timescale 1ns/1ns
module acp_checker (
    input logic        mclk,
    input logic        rst,
    input logic        reg_we,
    input logic [7:0]  reg_addr,
    input logic [7:0]  reg_wdata,
    input logic [7:0]  reg_rdata_q,
    input logic        out_valid_q,
    input logic        out_ready,
    input logic [1:0]  out_axis_q,
    input logic [15:0] out_data_q,
    input logic        tap_triple_en_q,
    input logic [1:0]  tap_axis_q,
    input logic        overscale_flag_q,
    input logic        excitation_off_q,
    input logic        second_decim_en_q,
    input logic        first_decim_16_q,
    input logic        droop_en_q,
    input logic        equalizer_en_q,
    input logic [1:0]  lowpass_cutoff_q,
    input logic        conv_start_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // a write lands on its edge, the decoded level one edge later
    sequence tap_wr;
        reg_we && reg_addr == 8'h47;
    endsequence
    sequence droop_off_wr;
        reg_we && reg_addr == 8'h50 && reg_wdata[7];
    endsequence
    tap_triple_a: assert property (
        tap_wr |-> ##2 tap_triple_en_q == |($past(reg_wdata, 2) & 8'h04))
        else $error("triple tap enable wrong");
    tap_axis_a: assert property (
        tap_wr |-> ##2 {6'h00, tap_axis_q} == ($past(reg_wdata, 2) & 8'h03))
        else $error("tap axis wrong");
    droop_skip_a: assert property (
        droop_off_wr |-> ##2 !droop_en_q)
        else $error("droop corrector still running");
    guard_detect_a: assert property (
        excitation_off_q |-> overscale_flag_q)
        else $error("excitation off without overrange");
    decim_ratio_a: assert property (
        first_decim_16_q |-> !second_decim_en_q)
        else $error("second stage on with 16x first stage");
    lowpass_skip_a: assert property (
        lowpass_cutoff_q != 2'b00 |-> !equalizer_en_q)
        else $error("lowpass active with equalizer running");
    // a stalled word must not move or change under the receiver
    out_hold_a: assert property (
        out_valid_q && !out_ready |=>
            out_valid_q && $stable(out_data_q) && $stable(out_axis_q))
        else $error("stalled output word changed");
    start_pulse_a: assert property (
        conv_start_q |=> !conv_start_q)
        else $error("conversion start longer than one cycle");
    unmapped_zero_a: assert property (
        reg_addr == 8'h60 |=> reg_rdata_q == 8'h00)
        else $error("unmapped address read nonzero");
endmodule // acp_checker

// >>> accel_signal_path_config_tb.sv
// self-checking bench for the signal path configuration block
// assumes acp_top and acp_map.vh on the include path, checker bound below
`timescale 1ns/1ns
`include "acp_map.vh"
module accel_signal_path_config_tb;
    logic        mclk, rst, reg_we, pulse_density_output, frame_sync_pin;
    logic        second_interrupt_pin, brownout_raw, overscale_raw;
    logic        in_valid, in_ready_q, in_lownoise, in_over, out_valid_q;
    logic        out_ready, temp_valid, temp_gain_high_q, tap_triple_en_q;
    logic        brownout_flag_q, overscale_flag_q, excitation_off_q;
    logic        second_decim_en_q, first_decim_16_q, recursive_en_q;
    logic        droop_en_q, equalizer_en_q, highpass_lownoise_q;
    logic        conv_start_q;
    logic [1:0]  in_axis, out_axis_q, tap_axis_q, lowpass_cutoff_q;
    logic [2:0]  mode_sel, highpass_corner_q;
    logic [4:0]  factory_temp_sens;
    logic [5:0]  factory_temp_ofs;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_q;
    logic [15:0] in_data, out_data_q, temp_raw, temp_out_q;
    int          n_errors = 0;
    int          cmp_count = 0;

    // short start period keeps the internal trigger test brief
    acp_top #(.CONV_PERIOD(10)) dut (.*);

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk16(input string nm, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk8(input string nm, input logic [7:0] e, g);
        chk16(nm, {8'h00, e}, {8'h00, g});
    endtask
    task automatic chk1(input string nm, input logic e, g);
        chk16(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    task settle;
        @(posedge mclk);
        #1;
    endtask
    // write strobe drops before the next write may raise it
    task automatic wr(input logic [7:0] a, d);
        @(posedge mclk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_we <= 1'b0;
        settle;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge mclk);
        reg_addr <= a;
        settle;
        settle;
        chk8("register", e, reg_rdata_q);
    endtask
    // word held until the edge that sees ready; valid left to caller
    task automatic send(input logic [1:0] ax, input logic ln, ov,
                        input logic [15:0] d);
        in_axis <= ax;
        in_lownoise <= ln;
        in_over <= ov;
        in_data <= d;
        in_valid <= 1'b1;
        do @(posedge mclk); while (!in_ready_q);
    endtask
    task automatic recv(input logic [1:0] ea, input logic [15:0] e);
        int n;
        in_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!(out_valid_q && out_ready) && n < 20);
        // a timeout shows as a missing valid, never as a quiet pass
        chk1("out valid", 1'b1, out_valid_q);
        chk8("out axis", {6'h00, ea}, {6'h00, out_axis_q});
        chk16("out word", e, out_data_q);
    endtask
    task automatic xfer(input logic [1:0] ax, input logic ln, ov,
                        input logic [15:0] d, e);
        send(ax, ln, ov, d);
        recv(ax, e);
    endtask
    task automatic temp(input logic [15:0] raw, e);
        @(posedge mclk);
        temp_raw <= raw;
        temp_valid <= 1'b1;
        @(posedge mclk);
        temp_valid <= 1'b0;
        settle;
        settle;
        chk16("temp out", e, temp_out_q);
    endtask
    task automatic starts(input int cyc, input logic [7:0] e);
        logic [7:0] c;
        c = 8'h00;
        repeat (cyc) begin
            settle;
            if (conv_start_q === 1'b1) c++;
        end
        chk8("start count", e, c);
    endtask

    task t_regs;
        logic [7:0] a, m;
        for (int i = 0; i < 12; i++) begin
            a = (i < 10) ? 8'h47 + i[7:0] : 8'h4b + i[7:0];
            case (a)
                8'h47: m = 8'h07;
                8'h48: m = 8'h1f;
                8'h49: m = 8'he7;
                8'h55: m = 8'h3f;
                8'h56: m = 8'hdf;
                default: m = 8'hff;
            endcase
            rd(a, 8'h00);
            wr(a, 8'hff);
            rd(a, m);
            wr(a, 8'h00);
        end
        wr(8'h60, 8'hff);
        rd(8'h60, 8'h00);
        $display("register test done");
    endtask
    task t_tap;
        for (int i = 0; i < 3; i++) begin
            wr(8'h47, {5'h00, i[0], i[1:0]});
            chk1("triple tap", i[0], tap_triple_en_q);
            chk8("tap axis", {6'h00, i[1:0]},
                 {6'h00, tap_axis_q});
        end
        wr(8'h47, 8'h00);
        $display("tap test done");
    endtask
    task t_guard;
        logic [7:0] c;
        brownout_raw <= 1'b1;
        overscale_raw <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? 8'h00 : 8'h02 << i;
            wr(8'h48, c);
            repeat (4) settle;
            chk1("brownout", ~c[4], brownout_flag_q);
            chk1("overscale", ~c[3], overscale_flag_q);
            chk1("excite off", ~c[3] & ~c[2], excitation_off_q);
        end
        brownout_raw <= 1'b0;
        overscale_raw <= 1'b0;
        wr(8'h48, 8'h00);
        $display("overrange flag test done");
    endtask
    task t_decim;
        wr(8'h49, 8'h80);
        chk1("second stage", 1'b0, second_decim_en_q);
        wr(8'h49, 8'h00);
        chk1("second stage", 1'b1, second_decim_en_q);
        chk1("first 16x", 1'b0, first_decim_16_q);
        wr(8'h49, 8'h40);
        chk1("second stage", 1'b0, second_decim_en_q);
        chk1("first 16x", 1'b1, first_decim_16_q);
        wr(8'h50, 8'h40);
        wr(8'h49, 8'h20);
        chk1("recursive", 1'b1, recursive_en_q);
        wr(8'h50, 8'h50);
        chk1("recursive", 1'b0, recursive_en_q);
        wr(8'h50, 8'h00);
        mode_sel <= `ACP_M_RBW;
        settle;
        settle;
        chk1("recursive", 1'b1, recursive_en_q);
        chk1("equalizer", 1'b0, equalizer_en_q);
        mode_sel <= `ACP_M_LP;
        settle;
        settle;
        chk1("recursive", 1'b1, recursive_en_q);
        chk1("equalizer", 1'b0, equalizer_en_q);
        mode_sel <= `ACP_M_HP;
        settle;
        settle;
        chk1("recursive", 1'b0, recursive_en_q);
        wr(8'h49, 8'h00);
        $display("decimation test done");
    endtask
    task t_filter;
        logic [2:0] c;
        for (int i = 0; i < 7; i++) begin
            c = i[2:0];
            wr(8'h50, {c[0], 1'b1, c[1:0], c[0], c});
            chk1("droop", ~c[0], droop_en_q);
            chk1("equalizer", 1'b0, equalizer_en_q);
            chk8("lowpass", {6'h00, c[1:0]},
                 {6'h00, lowpass_cutoff_q});
            chk8("corner", {5'h00, c},
                 {5'h00, highpass_corner_q});
            chk1("hp path", c[0], highpass_lownoise_q);
        end
        wr(8'h50, 8'h30);
        chk1("equalizer", 1'b1, equalizer_en_q);
        chk8("lowpass", 8'h00, {6'h00, lowpass_cutoff_q});
        mode_sel <= `ACP_M_ULP;
        wr(8'h50, 8'h50);
        chk8("lowpass", 8'h00, {6'h00, lowpass_cutoff_q});
        mode_sel <= `ACP_M_HP;
        wr(8'h50, 8'h00);
        $display("filter test done");
    endtask
    task t_trig;
        starts(40, 8'h04);
        wr(8'h49, 8'h01);
        starts(20, 8'h00);
        frame_sync_pin <= 1'b1;
        starts(8, 8'h01);
        wr(8'h49, 8'h03);
        frame_sync_pin <= 1'b0;
        starts(8, 8'h00);
        second_interrupt_pin <= 1'b1;
        starts(8, 8'h01);
        second_interrupt_pin <= 1'b0;
        wr(8'h49, 8'h00);
        $display("trigger test done");
    endtask
    task t_stream;
        wr(8'h4a, 8'h10);
        wr(8'h4d, 8'hf8);
        xfer(2'h0, 1'b0, 1'b0, 16'h0064, 16'h0066);
        xfer(2'h0, 1'b1, 1'b0, 16'h0064, 16'h0063);
        wr(8'h4f, 8'h08);
        xfer(2'h2, 1'b1, 1'b0, 16'h0064, 16'h0065);
        xfer(2'h0, 1'b0, 1'b0, 16'h7fff, 16'h7fff);
        xfer(2'h3, 1'b0, 1'b1, 16'hfffb, 16'h8000);
        xfer(2'h3, 1'b0, 1'b1, 16'h0005, 16'h7fff);
        wr(8'h48, 8'h01);
        xfer(2'h1, 1'b0, 1'b0, 16'h012c, 16'h012c);
        xfer(2'h1, 1'b0, 1'b1, 16'h0007, 16'h012c);
        wr(8'h48, 8'h02);
        xfer(2'h3, 1'b0, 1'b1, 16'h0007, 16'h0007);
        wr(8'h48, 8'h08);
        xfer(2'h3, 1'b0, 1'b1, 16'h0007, 16'h0007);
        wr(8'h48, 8'h00);
        pulse_density_output <= 1'b1;
        settle;
        xfer(2'h3, 1'b0, 1'b1, 16'h0007, 16'h0007);
        pulse_density_output <= 1'b0;
        wr(8'h50, 8'h01);
        wr(8'h49, 8'h04);
        xfer(2'h3, 1'b0, 1'b0, 16'hfffb, 16'hfffc);
        xfer(2'h3, 1'b0, 1'b0, 16'h0005, 16'h0005);
        xfer(2'h3, 1'b1, 1'b0, 16'hfffb, 16'hfffb);
        wr(8'h49, 8'h00);
        xfer(2'h3, 1'b0, 1'b0, 16'hfffb, 16'hfffb);
        wr(8'h50, 8'h00);
        $display("stream test done");
    endtask
    // two words fit while the receiver stalls, a third is refused
    task t_stall;
        out_ready <= 1'b0;
        send(2'h3, 1'b0, 1'b0, 16'h0001);
        send(2'h3, 1'b0, 1'b0, 16'h0002);
        in_valid <= 1'b0;
        settle;
        chk1("in ready", 1'b0, in_ready_q);
        out_ready <= 1'b1;
        recv(2'h3, 16'h0001);
        recv(2'h3, 16'h0002);
        settle;
        chk1("out valid", 1'b0, out_valid_q);
        $display("stall test done");
    endtask
    task t_temp;
        factory_temp_ofs <= 6'h3f;
        factory_temp_sens <= 5'h01;
        temp(16'h03e8, 16'h03eb);
        wr(8'h55, 8'h05);
        wr(8'h56, 8'h90);
        temp(16'h03e8, 16'h037c);
        wr(8'h56, 8'h40);
        chk1("temp gain", 1'b1, temp_gain_high_q);
        temp(16'h03e8, 16'h03eb);
        $display("temperature test done");
    endtask

    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        out_ready = 1'b1;
        {reg_we, reg_addr, reg_wdata, mode_sel, pulse_density_output,
         frame_sync_pin, second_interrupt_pin, brownout_raw, overscale_raw,
         in_valid, in_axis, in_lownoise, in_over, in_data, temp_valid,
         temp_raw, factory_temp_ofs, factory_temp_sens} = '0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_regs;
        t_tap;
        t_guard;
        t_decim;
        t_filter;
        t_trig;
        t_stream;
        t_stall;
        t_temp;
        wrap_up;
    end

    // the tests need well under a thousand cycles; this limit is 10000 cycles
    initial begin
        #400000;
        n_errors++;
        $display("[ERR] watchdog expected finish seen hang");
        wrap_up;
    end
endmodule // accel_signal_path_config_tb

bind acp_top acp_checker u_chk (.*);
